/* logic/fedc_dscr.sv */
// 11-bit key generator for the descrambler, open loop while acquiring.
// assumes shift_en marks one received bit and clr comes from lock logic.
`timescale 1ns/100ps
`default_nettype none
module fedc_dscr
(
   input  wire logic mclk,      // 50 MHz clock
   input  wire logic rst_b,     // async reset, active low
   input  wire logic shift_en,  // one bit time
   input  wire logic sd_bit,    // scrambled bit
   input  wire logic closed,    // run closed loop (locked)
   input  wire logic clr,       // wipe key state
   output logic      key        // key bit for this bit time
);

   logic [fedc_pkg::LFSR_W-1:0] lfsr_q, lfsr_d;

   // open loop assumes idle: key equals the inverted scrambled bit
   always_comb
   begin
      key    = lfsr_q[fedc_pkg::TAP_HI] ^ lfsr_q[fedc_pkg::TAP_LO];
      lfsr_d = lfsr_q;
      if (clr)
         lfsr_d = '0;
      else if (shift_en)
         lfsr_d = {lfsr_q[fedc_pkg::LFSR_W-2:0], closed ? key : !sd_bit};
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         lfsr_q <= '0;
      else
         lfsr_q <= lfsr_d;
   end

   property p_dscr_open_load;
      @(posedge mclk) disable iff (!rst_b)
      shift_en && !closed && !clr |=> lfsr_q[0] == !$past(sd_bit);
   endproperty
   a_dscr_open_load : assert property (p_dscr_open_load)
      else $error("open loop key did not follow the line");

   property p_dscr_clr;
      @(posedge mclk) disable iff (!rst_b)
      clr |=> lfsr_q == '0;
   endproperty
   a_dscr_clr : assert property (p_dscr_clr)
      else $error("key state not wiped on loss of lock");

endmodule : fedc_dscr
`default_nettype wire

/* logic/fedc_line_code.sv */
// top of the 100 Mb/s line-code path: tx split, rx decode, descrambler
// lock with hold timer, 5-bit grouping, alignment and nibble decode.
// assumes rx levels come from the equaliser on mclk, valid at rx_bit_en.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - tx ones alternate between two drive streams
// - transmit path is three-level only, no binary
// - received stream delivered as synchronous 4-bit nibbles
// - link pulses alone never raise signal detect
// - three-level symbols decoded to binary nrzi
// - nrzi converted to nrz before descrambling
// - received bits grouped into 5-bit symbols
// - plain bit is scrambled bit xor key
// - lock after 12 idle groups, then output
// - lock starts a 722 us hold countdown
// - 58 idle bit times reload the timer
// - timer expiry drops lock and clears the key, run count and alignment
// - key from 11-bit lfsr, open loop while acquiring, closed loop once locked
// - j/k pair fixes the code-group boundary
module fedc_line_code
#(
   parameter int HOLD_CYC = fedc_pkg::HOLD_CYC  // hold timer cycles
)
(
   input  wire logic       mclk,        // 50 MHz clock
   input  wire logic       rst_b,       // async reset, active low
   input  wire logic       tx_en,       // transmit active
   input  wire logic       tx_nrz,      // scrambled tx bit
   input  wire logic       rx_bit_en,   // one pulse per rx bit time
   input  wire logic       rx_lvl_pos,  // equalised level is positive
   input  wire logic       rx_lvl_neg,  // equalised level is negative
   output logic            tx_pos,      // positive drive stream
   output logic            tx_neg,      // negative drive stream
   output logic            sig_det,     // 100 Mb/s signal detect
   output logic            desc_lock,   // descrambler locked
   output logic [4:0]      rx_sym5,     // unaligned 5-bit symbol
   output logic            rx_sym5_vld, // symbol strobe
   output logic            rx_aligned,  // boundary fixed by j/k
   output logic [3:0]      rx_nib,      // decoded nibble
   output logic            rx_nib_vld,  // nibble strobe
   output logic            rx_nib_err   // invalid code-group
);

   localparam int HOLD_W = $clog2(HOLD_CYC + 1);
   localparam logic [HOLD_W-1:0] HOLD_LD = HOLD_W'(HOLD_CYC);
   localparam logic [fedc_pkg::RUN_W-1:0] RUN_LOCK =
      fedc_pkg::RUN_W'(fedc_pkg::LOCK_BITS - 1);
   localparam logic [fedc_pkg::RUN_W-1:0] RUN_RELOAD =
      fedc_pkg::RUN_W'(fedc_pkg::RELOAD_BITS - 1);
   localparam logic [fedc_pkg::SD_ACT_W-1:0] SD_ON =
      fedc_pkg::SD_ACT_W'(fedc_pkg::SD_ON_BITS);
   localparam logic [fedc_pkg::SD_GAP_W-1:0] SD_GAP =
      fedc_pkg::SD_GAP_W'(fedc_pkg::SD_GAP_BITS);

   // 5b code-group to {invalid, nibble}; j and k give the preamble nibble
   function automatic logic [4:0] fedc_dec5(input logic [4:0] cg);
      logic [4:0] r;
      r = 5'h10;
      case (cg)
         5'h1E: r = 5'h00;
         5'h09: r = 5'h01;
         5'h14: r = 5'h02;
         5'h15: r = 5'h03;
         5'h0A: r = 5'h04;
         5'h0B: r = 5'h05;
         5'h0E: r = 5'h06;
         5'h0F: r = 5'h07;
         5'h12: r = 5'h08;
         5'h13: r = 5'h09;
         5'h16: r = 5'h0A;
         5'h17: r = 5'h0B;
         5'h1A: r = 5'h0C;
         5'h1B: r = 5'h0D;
         5'h1C: r = 5'h0E;
         5'h1D: r = 5'h0F;
         5'h18: r = 5'h05;
         5'h11: r = 5'h05;
         default: r = 5'h10;
      endcase
      return r;
   endfunction : fedc_dec5

   logic lvl_p_q, lvl_p_d, lvl_n_q, lvl_n_d;
   logic nrzi_q, nrzi_d;
   logic scrambled_bit_q, scrambled_bit_d;
   logic scr_vld_q, scr_vld_d;
   logic [fedc_pkg::SD_ACT_W-1:0] act_q, act_d;
   logic [fedc_pkg::SD_GAP_W-1:0] gap_q, gap_d;
   logic sig_det_q, sig_det_d;
   typedef fedc_pkg::fedc_lock_e fedc_lock_e_t;
   fedc_lock_e_t st_q, st_d;
   logic lock_q, lock_d;
   logic [fedc_pkg::RUN_W-1:0] run_q, run_d;
   logic [HOLD_W-1:0] hold_q, hold_d;
   logic lose_lock;
   logic key;
   logic plain_bit;
   logic [9:0] win;
   logic [8:0] sh_q, sh_d;
   logic [2:0] pcnt_q, pcnt_d, acnt_q, acnt_d;
   logic [4:0] sym5_q, sym5_d, dec;
   logic sym5_vld_q, sym5_vld_d;
   logic aligned_q, aligned_d;
   logic [3:0] nib_q, nib_d;
   logic nib_vld_q, nib_vld_d, nib_err_q, nib_err_d;

   fedc_tx_mlt3 u_tx
   (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .tx_en  (tx_en),
      .tx_nrz (tx_nrz),
      .tx_pos (tx_pos),
      .tx_neg (tx_neg)
   );

   fedc_dscr u_dscr
   (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .shift_en (scr_vld_q),
      .sd_bit   (scrambled_bit_q),
      .closed   (lock_q),
      .clr      (lose_lock),
      .key      (key)
   );

   assign plain_bit = scrambled_bit_q ^ key;

   // front end: level change toggles nrzi, nrzi change gives nrz one
   always_comb
   begin
      lvl_p_d         = lvl_p_q;
      lvl_n_d         = lvl_n_q;
      nrzi_d          = nrzi_q;
      scrambled_bit_d = scrambled_bit_q;
      scr_vld_d       = rx_bit_en;
      if (rx_bit_en)
      begin
         lvl_p_d = rx_lvl_pos;
         lvl_n_d = rx_lvl_neg;
         nrzi_d  = nrzi_q ^ ((rx_lvl_pos != lvl_p_q) ||
                             (rx_lvl_neg != lvl_n_q));
         scrambled_bit_d = nrzi_d ^ nrzi_q;
      end
   end

   // signal detect wants sustained activity; a lone link pulse or an
   // flp burst leaves gaps far above SD_GAP and never fills act_q
   always_comb
   begin
      act_d = act_q;
      gap_d = gap_q;
      if (scr_vld_q)
      begin
         if (scrambled_bit_q)
         begin
            gap_d = '0;
            if (act_q != SD_ON)
               act_d = act_q + 1'b1;
         end
         else if (gap_q == SD_GAP)
            act_d = '0;
         else
            gap_d = gap_q + 1'b1;
      end
      sig_det_d = (act_d == SD_ON);
   end

   // lock: count idle bit times, then guard lock with the hold timer
   always_comb
   begin
      st_d      = st_q;
      run_d     = run_q;
      hold_d    = hold_q;
      lose_lock = 1'b0;
      case (st_q)
         fedc_pkg::ST_ACQ:
         begin
            if (scr_vld_q)
            begin
               if (!plain_bit)
                  run_d = '0;
               else if (run_q == RUN_LOCK)
               begin
                  st_d   = fedc_pkg::ST_LOCK;
                  run_d  = '0;
                  hold_d = HOLD_LD;
               end
               else
                  run_d = run_q + 1'b1;
            end
         end
         fedc_pkg::ST_LOCK:
         begin
            if (hold_q == '0)
            begin
               st_d      = fedc_pkg::ST_ACQ;
               run_d     = '0;
               lose_lock = 1'b1;
            end
            else
            begin
               hold_d = hold_q - 1'b1;
               if (scr_vld_q)
               begin
                  if (!plain_bit)
                     run_d = '0;
                  else if (run_q == RUN_RELOAD)
                  begin
                     run_d  = '0;
                     hold_d = HOLD_LD;
                  end
                  else
                     run_d = run_q + 1'b1;
               end
            end
         end
         default: st_d = fedc_pkg::ST_ACQ;
      endcase
      lock_d = (st_d == fedc_pkg::ST_LOCK);
   end

   // grouping only while locked; alignment waits for the j/k pair
   always_comb
   begin
      win        = {sh_q, plain_bit};
      dec        = fedc_dec5(win[4:0]);
      sh_d       = sh_q;
      pcnt_d     = pcnt_q;
      acnt_d     = acnt_q;
      sym5_d     = sym5_q;
      aligned_d  = aligned_q;
      nib_d      = nib_q;
      nib_err_d  = nib_err_q;
      sym5_vld_d = 1'b0;
      nib_vld_d  = 1'b0;
      if (!lock_q || lose_lock)
      begin
         sh_d      = '0;
         pcnt_d    = '0;
         acnt_d    = '0;
         aligned_d = 1'b0;
      end
      else if (scr_vld_q)
      begin
         sh_d   = win[8:0];
         pcnt_d = (pcnt_q == 3'h4) ? 3'h0 : pcnt_q + 1'b1;
         if (pcnt_q == 3'h4)
         begin
            sym5_d     = win[4:0];
            sym5_vld_d = 1'b1;
         end
         if (win == {fedc_pkg::CG_J, fedc_pkg::CG_K})
         begin
            aligned_d = 1'b1;
            acnt_d    = 3'h0;
            nib_d     = dec[3:0];
            nib_err_d = dec[4];
            nib_vld_d = 1'b1;
         end
         else if (aligned_q)
         begin
            acnt_d = (acnt_q == 3'h4) ? 3'h0 : acnt_q + 1'b1;
            if (acnt_q == 3'h4)
            begin
               nib_d     = dec[3:0];
               nib_err_d = dec[4];
               nib_vld_d = 1'b1;
            end
         end
      end
   end

   // registers of all receive groups
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lvl_p_q         <= 1'b0;
         lvl_n_q         <= 1'b0;
         nrzi_q          <= 1'b0;
         scrambled_bit_q <= 1'b0;
         scr_vld_q       <= 1'b0;
         act_q           <= '0;
         gap_q           <= '0;
         sig_det_q       <= 1'b0;
         st_q            <= fedc_pkg::ST_ACQ;
         lock_q          <= 1'b0;
         run_q           <= '0;
         hold_q          <= '0;
         sh_q            <= '0;
         pcnt_q          <= '0;
         acnt_q          <= '0;
         sym5_q          <= '0;
         sym5_vld_q      <= 1'b0;
         aligned_q       <= 1'b0;
         nib_q           <= '0;
         nib_vld_q       <= 1'b0;
         nib_err_q       <= 1'b0;
      end
      else
      begin
         lvl_p_q         <= lvl_p_d;
         lvl_n_q         <= lvl_n_d;
         nrzi_q          <= nrzi_d;
         scrambled_bit_q <= scrambled_bit_d;
         scr_vld_q       <= scr_vld_d;
         act_q           <= act_d;
         gap_q           <= gap_d;
         sig_det_q       <= sig_det_d;
         st_q            <= st_d;
         lock_q          <= lock_d;
         run_q           <= run_d;
         hold_q          <= hold_d;
         sh_q            <= sh_d;
         pcnt_q          <= pcnt_d;
         acnt_q          <= acnt_d;
         sym5_q          <= sym5_d;
         sym5_vld_q      <= sym5_vld_d;
         aligned_q       <= aligned_d;
         nib_q           <= nib_d;
         nib_vld_q       <= nib_vld_d;
         nib_err_q       <= nib_err_d;
      end
   end

   assign sig_det     = sig_det_q;
   assign desc_lock   = lock_q;
   assign rx_sym5     = sym5_q;
   assign rx_sym5_vld = sym5_vld_q;
   assign rx_aligned  = aligned_q;
   assign rx_nib      = nib_q;
   assign rx_nib_vld  = nib_vld_q;
   assign rx_nib_err  = nib_err_q;

   sequence s_last_idle;
      scr_vld_q && plain_bit && run_q == RUN_LOCK && !lock_q;
   endsequence
   sequence s_jk;
      lock_q && !lose_lock && scr_vld_q &&
      win == {fedc_pkg::CG_J, fedc_pkg::CG_K};
   endsequence

   property p_lock_acq;
      @(posedge mclk) disable iff (!rst_b)
      s_last_idle |=> desc_lock && hold_q == HOLD_LD;
   endproperty
   a_lock_acq : assert property (p_lock_acq)
      else $error("lock or timer load missing after idle run");

   property p_lock_cause;
      @(posedge mclk) disable iff (!rst_b)
      $rose(desc_lock) |-> $past(run_q) == RUN_LOCK;
   endproperty
   a_lock_cause : assert property (p_lock_cause)
      else $error("lock taken without full idle run");

   property p_reload;
      @(posedge mclk) disable iff (!rst_b)
      lock_q && hold_q != '0 && scr_vld_q && plain_bit &&
      run_q == RUN_RELOAD |=> hold_q == HOLD_LD;
   endproperty
   a_reload : assert property (p_reload)
      else $error("hold timer not reloaded by idle run");

   property p_expire;
      @(posedge mclk) disable iff (!rst_b)
      lock_q && hold_q == '0 |=> !desc_lock && !rx_aligned && run_q == '0;
   endproperty
   a_expire : assert property (p_expire)
      else $error("expired hold timer kept lock");

   property p_unlocked_quiet;
      @(posedge mclk) disable iff (!rst_b)
      !lock_q ##1 !lock_q |-> !rx_sym5_vld && !rx_nib_vld;
   endproperty
   a_unlocked_quiet : assert property (p_unlocked_quiet)
      else $error("symbols emitted while unlocked");

   property p_align;
      @(posedge mclk) disable iff (!rst_b)
      s_jk |=> rx_aligned && rx_nib_vld && rx_nib == 4'h5
               ##1 !rx_nib_vld [*4];
   endproperty
   a_align : assert property (p_align)
      else $error("j/k did not fix the group boundary");

   property p_sd_gap;
      @(posedge mclk) disable iff (!rst_b)
      scr_vld_q && !scrambled_bit_q && gap_q == SD_GAP |=> !sig_det;
   endproperty
   a_sd_gap : assert property (p_sd_gap)
      else $error("signal detect held across a quiet gap");

   property p_nrz;
      @(posedge mclk) disable iff (!rst_b)
      rx_bit_en |=> scrambled_bit_q ==
         (($past(rx_lvl_pos) != $past(lvl_p_q)) ||
          ($past(rx_lvl_neg) != $past(lvl_n_q)));
   endproperty
   a_nrz : assert property (p_nrz)
      else $error("line change not decoded as one");

   // check-only helpers: bits since the last nibble strobe and a j/k mark;
   // counting bits keeps the pace check valid at any rx_bit_en spacing
   logic [3:0] pace_q, pace_d;
   logic       jk_q, jk_d;

   always_comb
   begin
      pace_d = rx_nib_vld ? 4'h0 : pace_q;
      if (scr_vld_q && pace_d != 4'hF)
         pace_d = pace_d + 4'h1;
      jk_d = lock_q && !lose_lock && scr_vld_q &&
             (win == {fedc_pkg::CG_J, fedc_pkg::CG_K});
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pace_q <= 4'h0;
         jk_q   <= 1'b0;
      end
      else
      begin
         pace_q <= pace_d;
         jk_q   <= jk_d;
      end
   end

   property p_nib_pace;
      @(posedge mclk) disable iff (!rst_b)
      rx_nib_vld && !jk_q |-> pace_q == 4'h5;
   endproperty
   a_nib_pace : assert property (p_nib_pace)
      else $error("nibble strobes not five bits apart");

endmodule : fedc_line_code
`default_nettype wire

/* logic/fedc_pkg.sv */
// package for the line-code and descrambler path of a 100 Mb/s phy.
// assumes one bit time per rx_bit_en pulse and a 50 MHz mclk.
package fedc_pkg;

   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int HOLD_TIME_NS  = 722000;
   // longest time, so rounded down
   localparam int HOLD_CYC      = HOLD_TIME_NS / CLK_PERIOD_NS;

   // idle recognition and hold timer reload, in bit times
   localparam int CG_BITS        = 5;
   localparam int IDLE_GRP_LOCK  = 12;
   localparam int LOCK_BITS      = IDLE_GRP_LOCK * CG_BITS;
   localparam int RELOAD_BITS    = 58;
   localparam int RUN_W          = 7;

   // code-groups
   localparam logic [4:0] CG_IDLE = 5'h1F;
   localparam logic [4:0] CG_J    = 5'h18;
   localparam logic [4:0] CG_K    = 5'h11;

   // key generator: x^11 + x^9 + 1
   localparam int LFSR_W = 11;
   localparam int TAP_HI = 10;
   localparam int TAP_LO = 8;

   // signal detect, in bit times
   localparam int SD_ON_BITS  = 64;
   localparam int SD_GAP_BITS = 32;
   localparam int SD_ACT_W    = 7;
   localparam int SD_GAP_W    = 6;

   typedef enum logic {ST_ACQ, ST_LOCK} fedc_lock_e;

endpackage : fedc_pkg

/* logic/fedc_tx_mlt3.sv */
// transmit nrzi encoder and three-level split into two drive streams.
// assumes tx_nrz/tx_en come from scrambler logic on mclk, one bit a cycle.
`timescale 1ns/100ps
`default_nettype none
module fedc_tx_mlt3
(
   input  wire logic mclk,    // 50 MHz clock
   input  wire logic rst_b,   // async reset, active low
   input  wire logic tx_en,   // transmit active
   input  wire logic tx_nrz,  // scrambled nrz bit
   output logic      tx_pos,  // drive positive side
   output logic      tx_neg   // drive negative side
);

   logic nrzi_q, nrzi_d;
   logic last_neg_q, last_neg_d;
   logic pos_q, pos_d, neg_q, neg_d;
   logic one_ev;

   // a one flips the nrzi level; that flip is the event the driver sees
   always_comb
   begin
      nrzi_d     = nrzi_q ^ tx_nrz;
      one_ev     = nrzi_d ^ nrzi_q;
      pos_d      = pos_q;
      neg_d      = neg_q;
      last_neg_d = last_neg_q;
      // always three-level; no plain binary path exists
      if (!tx_en)
      begin
         pos_d  = 1'b0;
         neg_d  = 1'b0;
         nrzi_d = nrzi_q;
      end
      else if (one_ev)
      begin
         // from zero go to the side not used last time
         if (!pos_q && !neg_q)
         begin
            pos_d      = last_neg_q;
            neg_d      = !last_neg_q;
            last_neg_d = !last_neg_q;
         end
         else
         begin
            pos_d = 1'b0;
            neg_d = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         nrzi_q     <= 1'b0;
         last_neg_q <= 1'b1;
         pos_q      <= 1'b0;
         neg_q      <= 1'b0;
      end
      else
      begin
         nrzi_q     <= nrzi_d;
         last_neg_q <= last_neg_d;
         pos_q      <= pos_d;
         neg_q      <= neg_d;
      end
   end

   assign tx_pos = pos_q;
   assign tx_neg = neg_q;

   property p_tx_one_leaves_zero;
      @(posedge mclk) disable iff (!rst_b)
      tx_en && tx_nrz && !tx_pos && !tx_neg |=> tx_pos != tx_neg;
   endproperty
   a_tx_one_leaves_zero : assert property (p_tx_one_leaves_zero)
      else $error("one at zero level did not reach a side");

   property p_tx_zero_holds;
      @(posedge mclk) disable iff (!rst_b)
      tx_en && !tx_nrz |=> $stable(tx_pos) && $stable(tx_neg);
   endproperty
   a_tx_zero_holds : assert property (p_tx_zero_holds)
      else $error("zero bit changed the line level");

   property p_tx_never_both;
      @(posedge mclk) disable iff (!rst_b)
      !(tx_pos && tx_neg);
   endproperty
   a_tx_never_both : assert property (p_tx_never_both)
      else $error("both drive streams active");

endmodule : fedc_tx_mlt3
`default_nettype wire

/* tb/fedc_far_end.sv */
// far-side link partner: scrambles plain bits, sends three-level symbols.
// assumes the bench calls its tasks; bits leave at falling mclk edges.
`timescale 1ns/100ps
`default_nettype none
module fedc_far_end
(
   input  wire logic mclk,        // 50 MHz clock
   output logic      rx_bit_en,   // one pulse per bit time
   output logic      rx_lvl_pos,  // line level positive
   output logic      rx_lvl_neg   // line level negative
);
   logic [10:0] scr_q  = 11'h5A3;  // nonzero seed, value is arbitrary
   int          lvl_q  = 0;        // line level -1, 0 or +1
   int          side_q = -1;       // last side used, first one goes up

   // line starts at zero level with no bit pending
   initial
   begin
      rx_bit_en  = 1'b0;
      rx_lvl_pos = 1'b0;
      rx_lvl_neg = 1'b0;
   end

   // raw bit onto the line; a cable holds its level between bits
   task automatic send_raw(input logic b, input int gap);
      @(negedge mclk);
      if (b)
         lvl_q = (lvl_q != 0) ? 0 : -side_q;
      if (lvl_q != 0)
         side_q = lvl_q;
      rx_bit_en  = 1'b1;
      rx_lvl_pos = (lvl_q > 0);
      rx_lvl_neg = (lvl_q < 0);
      @(negedge mclk);
      rx_bit_en = 1'b0;
      repeat (gap) @(negedge mclk);
   endtask : send_raw

   // closed-loop key, x^11 + x^9 + 1, xored onto each plain bit
   task automatic send_bit(input logic b, input int gap);
      logic key;
      key   = scr_q[10] ^ scr_q[8];
      scr_q = {scr_q[9:0], key};
      send_raw(b ^ key, gap);
   endtask : send_bit
endmodule : fedc_far_end
`default_nettype wire

/* tb/fedc_line_code_test.sv */
// self-checking bench for the line-code path with a shortened hold timer.
// assumes fedc_far_end drives the receive levels on falling edges.
`timescale 1ns/100ps
`default_nettype none
module fedc_line_code_test;
   localparam int HOLD = 400;
   logic       mclk   = 1'b0;
   logic       rst_b  = 1'b0;
   logic       tx_en  = 1'b0;
   logic       tx_nrz = 1'b0;
   logic       rx_bit_en;
   logic       rx_lvl_pos;
   logic       rx_lvl_neg;
   logic       tx_pos;
   logic       tx_neg;
   logic       sig_det;
   logic       desc_lock;
   logic [4:0] rx_sym5;
   logic       rx_sym5_vld;
   logic       rx_aligned;
   logic [3:0] rx_nib;
   logic       rx_nib_vld;
   logic       rx_nib_err;
   int         fail_count   = 0;
   int         total_checks = 0;
   int         lvl  = 0;
   int         side = -1;
   bit         idle_only = 1'b0;
   logic [1:0] exp_tx;
   logic [3:0] n;
   logic [1:0] txq[$];
   logic [3:0] nibq[$];
   logic [4:0] code_tab[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
      5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

   always #10 mclk = ~mclk;

   fedc_line_code #(.HOLD_CYC(HOLD)) fedc_line_code_inst
   (
      .mclk(mclk), .rst_b(rst_b), .tx_en(tx_en), .tx_nrz(tx_nrz),
      .rx_bit_en(rx_bit_en), .rx_lvl_pos(rx_lvl_pos),
      .rx_lvl_neg(rx_lvl_neg), .tx_pos(tx_pos), .tx_neg(tx_neg),
      .sig_det(sig_det), .desc_lock(desc_lock), .rx_sym5(rx_sym5),
      .rx_sym5_vld(rx_sym5_vld), .rx_aligned(rx_aligned),
      .rx_nib(rx_nib), .rx_nib_vld(rx_nib_vld), .rx_nib_err(rx_nib_err)
   );

   fedc_far_end fedc_far_end_inst
   (
      .mclk(mclk), .rx_bit_en(rx_bit_en), .rx_lvl_pos(rx_lvl_pos),
      .rx_lvl_neg(rx_lvl_neg)
   );

   task automatic chk(input bit ok, input string msg);
      total_checks++;
      if (!ok)
      begin
         fail_count++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   // reference three-level split; disabled drive keeps the nrzi level
   task automatic push_tx;
      if (tx_en && tx_nrz)
         lvl = (lvl != 0) ? 0 : -side;
      if (lvl != 0)
         side = lvl;
      // a disabled driver leaves the line at zero; the last side is kept
      if (!tx_en)
         lvl = 0;
      txq.push_back(tx_en ? {lvl > 0, lvl < 0} : 2'b00);
   endtask : push_tx

   task automatic send_sym(input logic [4:0] s);
      for (int i = 4; i >= 0; i--)
         fedc_far_end_inst.send_bit(s[i], 0);
   endtask : send_sym

   // monitor: results checked just after the edge that makes them
   always @(posedge mclk)
   begin
      #1;
      if (txq.size() > 0)
      begin
         exp_tx = txq.pop_front();
         chk({tx_pos, tx_neg} === exp_tx, "tx drive");
      end
      if (rx_nib_vld === 1'b1 && nibq.size() > 0)
         chk(rx_nib === nibq.pop_front() && rx_nib_err === 1'b0, "nib");
      else if (rx_nib_vld === 1'b1)
         chk(rx_nib_err === 1'b1, "idle nibble not flagged");
      if (rx_sym5_vld === 1'b1 && idle_only)
         chk(rx_sym5 === 5'h1F, "idle symbol");
   end

   // watchdog: the sequence needs about 1660 cycles
   initial
   begin
      #(20 * 8000);
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end

   initial
   begin
      void'($urandom(57365));
      repeat (12) @(negedge mclk);
      chk(desc_lock === 1'b0 && tx_pos === 1'b0, "reset state");
      rst_b = 1'b1;
      for (int i = 0; i < 64; i++)
      begin
         @(negedge mclk);
         tx_en  = ($urandom % 8) != 0;
         tx_nrz = 1'($urandom);
         push_tx();
      end
      @(negedge mclk);
      tx_en = 1'b0;
      push_tx();
      repeat (2) @(negedge mclk);
      $display("tx split test done");
      // sparse pulses with long silences, like link pulses
      repeat (4)
      begin
         fedc_far_end_inst.send_raw(1'b1, 0);
         repeat (40) fedc_far_end_inst.send_raw(1'b0, 0);
      end
      chk(sig_det === 1'b0, "pulses gave detect");
      $display("link pulse test done");
      idle_only = 1'b1;
      repeat (59) fedc_far_end_inst.send_bit(1'b1, 0);
      chk(desc_lock === 1'b0, "early lock");
      repeat (20) fedc_far_end_inst.send_bit(1'b1, 0);
      repeat (3) @(negedge mclk);
      chk(desc_lock === 1'b1, "no lock on idle");
      $display("lock test done");
      idle_only = 1'b0;
      nibq.push_back(4'h5);
      send_sym(5'h18);
      send_sym(5'h11);
      repeat (8)
      begin
         n = 4'($urandom);
         nibq.push_back(n);
         send_sym(code_tab[n]);
      end
      repeat (4) @(negedge mclk);
      chk(rx_aligned === 1'b1 && nibq.size() == 0, "alignment");
      $display("alignment test done");
      // steady idles every other cycle keep reloading the timer
      repeat (HOLD / 2) fedc_far_end_inst.send_bit(1'b1, 0);
      chk(desc_lock === 1'b1, "lock lost on idles");
      chk(sig_det === 1'b1, "no signal detect");
      repeat (HOLD + 20) @(negedge mclk);
      chk(desc_lock === 1'b0 && rx_aligned === 1'b0, "no drop");
      idle_only = 1'b1;
      repeat (80) fedc_far_end_inst.send_bit(1'b1, 0);
      repeat (3) @(negedge mclk);
      chk(desc_lock === 1'b1, "no relock");
      $display("hold timer test done");
      rst_b = 1'b0;
      @(negedge mclk);
      chk(desc_lock === 1'b0 && sig_det === 1'b0, "mid reset");
      rst_b = 1'b1;
      $display("reset test done");
      tally_and_finish();
   end
endmodule : fedc_line_code_test
`default_nettype wire
